// >>> design/dual_slope_pwm_timer16.sv
`timescale 1ns/10ps
`default_nettype none
`include "pwm_timer_defs.svh"
module dual_slope_pwm_timer16
	import pwm_timer_pkg::*;
#(
	parameter int PrescaleWidth = 10
)
(
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic [2:0] clockSelect,
	input  wire logic [3:0] waveformMode,
	input  wire logic [1:0] compareModeA,
	input  wire logic [1:0] compareModeB,
	input  wire logic       compareWriteA,
	input  wire logic       compareWriteB,
	input  wire count_t     compareWriteData,
	input  wire logic       captureWrite,
	input  wire count_t     captureWriteData,
	input  wire logic       counterWrite,
	input  wire count_t     counterWriteData,
	input  wire logic       overflowClear,
	input  wire logic       overflowServiced,
	input  wire logic       compareClearA,
	input  wire logic       compareServicedA,
	input  wire logic       compareClearB,
	input  wire logic       compareServicedB,
	input  wire logic       captureClear,
	input  wire logic       captureServiced,
	input  wire logic       overflowIrqEnable,
	input  wire logic       compareIrqEnableA,
	input  wire logic       compareIrqEnableB,
	input  wire logic       captureIrqEnable,
	input  wire logic       wavePinDirectionA,
	input  wire logic       wavePinDirectionB,
	input  wire logic       portDataA,
	input  wire logic       portDataB,
	output count_t          counterValue,
	output logic            countingUp,
	output count_t          compareRegA,
	output count_t          compareRegB,
	output count_t          captureReg,
	output logic            overflowFlag,
	output logic            compareMatchFlagA,
	output logic            compareMatchFlagB,
	output logic            captureFlag,
	output logic            overflowIrq,
	output logic            compareIrqA,
	output logic            compareIrqB,
	output logic            captureIrq,
	output logic            waveOutA,
	output logic            waveOutB,
	output logic            wavePinA,
	output logic            wavePinB,
	output logic            wavePinOeA_n,
	output logic            wavePinOeB_n
);
	timer_link_if link ();

	logic       tick;
	count_t     count_q;
	count_t     count_d;
	slope_t     slope_q;
	slope_t     slope_d;
	count_t     capture_q;
	count_t     capture_d;
	logic       block_q;
	logic       block_d;
	logic       ovf_q;
	logic       ovf_d;
	logic       cap_q;
	logic       cap_d;
	count_t     topValue;
	count_t     writeMask;
	logic       phaseCorrect;
	logic       freqCorrect;
	logic       dualSlope;
	logic       topFromCapture;
	logic       topFromCompareA;
	logic       atTop;
	logic       atBottom;
	logic       topEvent;
	logic       bottomEvent;
	logic       slopeUpEff;
	logic [1:0] chMode [2];
	logic       chWrite [2];
	logic       chClear [2];
	count_t     chActive [2];
	logic       chLevel [2];
	logic       chConnected [2];
	logic       chFlag [2];
	logic       chDirection [2];
	logic       chPortData [2];
	logic       chPin [2];

	prescale_divider
	#(
		.PrescaleWidth (PrescaleWidth)
	)
	u_prescale
	(
		.core_clk    (core_clk),
		.resetn      (resetn),
		.clockSelect (clockSelect),
		.tickEnable  (tick)
	);

	assign phaseCorrect = (waveformMode == `WGM_PC_8BIT) ||
	                      (waveformMode == `WGM_PC_9BIT) ||
	                      (waveformMode == `WGM_PC_10BIT) ||
	                      (waveformMode == `WGM_PC_CAP) ||
	                      (waveformMode == `WGM_PC_CMPA);
	assign freqCorrect = (waveformMode == `WGM_PFC_CAP) ||
	                     (waveformMode == `WGM_PFC_CMPA);
	assign dualSlope = phaseCorrect || freqCorrect;
	assign topFromCapture = (waveformMode == `WGM_PFC_CAP) ||
	                        (waveformMode == `WGM_PC_CAP);
	assign topFromCompareA = (waveformMode == `WGM_PFC_CMPA) ||
	                         (waveformMode == `WGM_PC_CMPA);

	// In the compare A modes top follows the active compare A, so a new top only lands at an update.
	assign topValue = (waveformMode == `WGM_PC_8BIT)  ? `TOP_8BIT :
	                  (waveformMode == `WGM_PC_9BIT)  ? `TOP_9BIT :
	                  (waveformMode == `WGM_PC_10BIT) ? `TOP_10BIT :
	                  topFromCapture ? capture_q :
	                  topFromCompareA ? chActive[0] :
	                  `CNT_FULL_MASK;
	assign writeMask = (waveformMode == `WGM_PC_8BIT)  ? `TOP_8BIT :
	                   (waveformMode == `WGM_PC_9BIT)  ? `TOP_9BIT :
	                   (waveformMode == `WGM_PC_10BIT) ? `TOP_10BIT :
	                   `CNT_FULL_MASK;

	assign atTop = (count_q == topValue);
	assign atBottom = (count_q == `CNT_BOTTOM);
	assign topEvent = tick && dualSlope && (slope_q == SlopeUp) && atTop;
	assign bottomEvent = tick && dualSlope && (slope_q == SlopeDown) &&
	                     atBottom;
	// The turning points belong to the slope that follows them; this is what
	// makes a compare at bottom stay low and a compare at top stay high.
	assign slopeUpEff = atBottom ? 1'b1 :
	                    atTop ? 1'b0 :
	                    (slope_q == SlopeUp);

	always_comb
	begin
		count_d = count_q;
		slope_d = slope_q;
		if (counterWrite)
			count_d = counterWriteData;
		else if (tick && dualSlope)
		begin
			unique case (slope_q)
				SlopeUp:
					if (atTop)
					begin
						slope_d = SlopeDown;
						count_d = count_q - `CNT_ONE;
					end
					else
						count_d = count_q + `CNT_ONE;
				SlopeDown:
					if (atBottom)
					begin
						slope_d = SlopeUp;
						count_d = count_q + `CNT_ONE;
					end
					else
						count_d = count_q - `CNT_ONE;
			endcase
		end
	end

	// The capture register is not double buffered; a low write may be missed.
	assign capture_d = captureWrite ? captureWriteData : capture_q;
	assign block_d = counterWrite || (block_q && !tick);
	assign ovf_d = bottomEvent ||
	               (ovf_q && !(overflowClear || overflowServiced));
	assign cap_d = (topEvent && topFromCapture) ||
	               (cap_q && !(captureClear || captureServiced));

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			count_q   <= `CNT_BOTTOM;
			slope_q   <= SlopeUp;
			capture_q <= `CNT_BOTTOM;
			block_q   <= 1'b0;
			ovf_q     <= 1'b0;
			cap_q     <= 1'b0;
		end
		else
		begin
			count_q   <= count_d;
			slope_q   <= slope_d;
			capture_q <= capture_d;
			block_q   <= block_d;
			ovf_q     <= ovf_d;
			cap_q     <= cap_d;
		end
	end

	assign link.tick = tick;
	assign link.count = count_q;
	assign link.slopeUpEff = slopeUpEff;
	// Phase correct loads at top, frequency correct at bottom.
	assign link.loadStrobe = phaseCorrect ? topEvent :
	                         (freqCorrect ? bottomEvent : 1'b0);
	assign link.matchBlock = block_q;
	assign link.writeMask = writeMask;
	assign link.toggleAllowed = waveformMode[`WGM_TOP_BIT];

	assign chMode[0] = compareModeA;
	assign chMode[1] = compareModeB;
	assign chWrite[0] = compareWriteA;
	assign chWrite[1] = compareWriteB;
	assign chClear[0] = compareClearA || compareServicedA;
	assign chClear[1] = compareClearB || compareServicedB;
	assign chDirection[0] = wavePinDirectionA;
	assign chDirection[1] = wavePinDirectionB;
	assign chPortData[0] = portDataA;
	assign chPortData[1] = portDataB;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_channel
			compare_channel
			#(
				.ToggleCapable (ch == 0)
			)
			u_channel
			(
				.core_clk      (core_clk),
				.resetn        (resetn),
				.link          (link.channel),
				.compareMode   (chMode[ch]),
				.writeStrobe   (chWrite[ch]),
				.writeData     (compareWriteData),
				.flagClear     (chClear[ch]),
				.activeCompare (chActive[ch]),
				.waveLevel     (chLevel[ch]),
				.pinConnected  (chConnected[ch]),
				.matchFlag     (chFlag[ch])
			);
			assign chPin[ch] = chConnected[ch] ? chLevel[ch] :
			                   chPortData[ch];
		end
	endgenerate

	assign counterValue = count_q;
	assign countingUp = (slope_q == SlopeUp);
	assign compareRegA = chActive[0];
	assign compareRegB = chActive[1];
	assign captureReg = capture_q;
	assign overflowFlag = ovf_q;
	assign compareMatchFlagA = chFlag[0];
	assign compareMatchFlagB = chFlag[1];
	assign captureFlag = cap_q;
	assign overflowIrq = ovf_q && overflowIrqEnable;
	assign compareIrqA = chFlag[0] && compareIrqEnableA;
	assign compareIrqB = chFlag[1] && compareIrqEnableB;
	assign captureIrq = cap_q && captureIrqEnable;
	assign waveOutA = chLevel[0];
	assign waveOutB = chLevel[1];
	assign wavePinA = chPin[0];
	assign wavePinB = chPin[1];
	assign wavePinOeA_n = !wavePinDirectionA;
	assign wavePinOeB_n = !wavePinDirectionB;
endmodule : dual_slope_pwm_timer16
`default_nettype wire

// >>> design/pwm_timer_defs.svh
`ifndef PWM_TIMER_DEFS_SVH
`define PWM_TIMER_DEFS_SVH

`define CNT_BOTTOM    16'h0000
`define CNT_ONE       16'h0001
`define CNT_FULL_MASK 16'hFFFF
`define TOP_8BIT      16'h00FF
`define TOP_9BIT      16'h01FF
`define TOP_10BIT     16'h03FF

`define WGM_PC_8BIT   4'h1
`define WGM_PC_9BIT   4'h2
`define WGM_PC_10BIT  4'h3
`define WGM_PFC_CAP   4'h8
`define WGM_PFC_CMPA  4'h9
`define WGM_PC_CAP    4'hA
`define WGM_PC_CMPA   4'hB
`define WGM_TOP_BIT   3

`define COM_OFF       2'h0
`define COM_TOGGLE    2'h1
`define COM_NONINV    2'h2
`define COM_INV       2'h3

`define CS_DIV1       3'h1
`define CS_DIV8       3'h2
`define CS_DIV64      3'h3
`define CS_DIV256     3'h4
`define CS_DIV1024    3'h5

`define PRE_ZERO      10'h000
`define PRE_ONE       10'h001
`define PRE_MASK8     10'h007
`define PRE_MASK64    10'h03F
`define PRE_MASK256   10'h0FF
`define PRE_MASK1024  10'h3FF

`endif

// >>> design/pwm_timer_pkg.sv
package pwm_timer_pkg;
	typedef enum logic [1:0]
	{
		SlopeUp   = 2'b01,
		SlopeDown = 2'b10
	} slope_t;
	typedef logic [15:0] count_t;
endpackage : pwm_timer_pkg

// >>> design/timer_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface timer_link_if;
	import pwm_timer_pkg::*;
	logic   tick;
	count_t count;
	logic   slopeUpEff;
	logic   loadStrobe;
	logic   matchBlock;
	count_t writeMask;
	logic   toggleAllowed;
	modport timer
	(
		output tick,
		output count,
		output slopeUpEff,
		output loadStrobe,
		output matchBlock,
		output writeMask,
		output toggleAllowed
	);
	modport channel
	(
		input tick,
		input count,
		input slopeUpEff,
		input loadStrobe,
		input matchBlock,
		input writeMask,
		input toggleAllowed
	);
endinterface : timer_link_if
`default_nettype wire

// >>> design/prescale_divider.sv
`timescale 1ns/10ps
`default_nettype none
`include "pwm_timer_defs.svh"
module prescale_divider
#(
	parameter int PrescaleWidth = 10
)
(
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic [2:0] clockSelect,
	output logic            tickEnable
);
	logic [PrescaleWidth-1:0] pre_q;
	logic [PrescaleWidth-1:0] pre_d;
	logic [PrescaleWidth-1:0] selMask;
	logic                     running;

	assign selMask = (clockSelect == `CS_DIV8)    ? `PRE_MASK8 :
	                 (clockSelect == `CS_DIV64)   ? `PRE_MASK64 :
	                 (clockSelect == `CS_DIV256)  ? `PRE_MASK256 :
	                 (clockSelect == `CS_DIV1024) ? `PRE_MASK1024 :
	                 `PRE_ZERO;
	assign running = (clockSelect >= `CS_DIV1) &&
	                 (clockSelect <= `CS_DIV1024);
	assign pre_d = running ? pre_q + `PRE_ONE : pre_q;
	// A stopped select freezes the prefix so a restart keeps its phase.
	assign tickEnable = running && ((pre_q & selMask) == selMask);

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			pre_q <= `PRE_ZERO;
		else
			pre_q <= pre_d;
	end
endmodule : prescale_divider
`default_nettype wire

// >>> design/compare_channel.sv
`timescale 1ns/10ps
`default_nettype none
`include "pwm_timer_defs.svh"
module compare_channel
	import pwm_timer_pkg::*;
#(
	parameter bit ToggleCapable = 1'b0
)
(
	input  wire logic       core_clk,
	input  wire logic       resetn,
	timer_link_if.channel   link,
	input  wire logic [1:0] compareMode,
	input  wire logic       writeStrobe,
	input  wire count_t     writeData,
	input  wire logic       flagClear,
	output count_t          activeCompare,
	output logic            waveLevel,
	output logic            pinConnected,
	output logic            matchFlag
);
	count_t buffer_q;
	count_t buffer_d;
	count_t active_q;
	count_t active_d;
	logic   level_q;
	logic   level_d;
	logic   flag_q;
	logic   flag_d;
	logic   match;
	logic   toggleOn;

	// A top below the compare value never equals it, so no match fires.
	assign match = link.tick && !link.matchBlock &&
	               (link.count == active_q);
	assign buffer_d = writeStrobe ? (writeData & link.writeMask) : buffer_q;
	assign active_d = link.loadStrobe ? buffer_q : active_q;
	assign toggleOn = ToggleCapable && link.toggleAllowed &&
	                  (compareMode == `COM_TOGGLE);
	assign pinConnected = (compareMode == `COM_NONINV) ||
	                      (compareMode == `COM_INV) || toggleOn;
	// Set beats clear so a match in the clearing cycle is not lost.
	assign flag_d = match || (flag_q && !flagClear);

	always_comb
	begin
		level_d = level_q;
		unique case (compareMode)
			`COM_NONINV:
				if (match)
					level_d = !link.slopeUpEff;
			`COM_INV:
				if (match)
					level_d = link.slopeUpEff;
			`COM_TOGGLE:
				if (match && toggleOn)
					level_d = !level_q;
			`COM_OFF:
				level_d = level_q;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			buffer_q <= `CNT_BOTTOM;
			active_q <= `CNT_BOTTOM;
			level_q  <= 1'b0;
			flag_q   <= 1'b0;
		end
		else
		begin
			buffer_q <= buffer_d;
			active_q <= active_d;
			level_q  <= level_d;
			flag_q   <= flag_d;
		end
	end

	assign activeCompare = active_q;
	assign waveLevel     = level_q;
	assign matchFlag     = flag_q;
endmodule : compare_channel
`default_nettype wire

// >>> verification/pwm_timer_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module pwm_timer_monitor
	import pwm_timer_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       resetn,
	input wire logic [2:0] clockSelect,
	input wire logic [3:0] waveformMode,
	input wire logic [1:0] compareModeA,
	input wire logic [1:0] compareModeB,
	input wire logic       counterWrite,
	input wire logic       overflowIrqEnable,
	input wire logic       wavePinDirectionA,
	input wire logic       portDataA,
	input wire count_t     counterValue,
	input wire logic       countingUp,
	input wire count_t     compareRegB,
	input wire count_t     captureReg,
	input wire logic       overflowFlag,
	input wire logic       compareMatchFlagB,
	input wire logic       overflowIrq,
	input wire logic       waveOutA,
	input wire logic       waveOutB,
	input wire logic       wavePinA,
	input wire logic       wavePinOeA_n
);
	default clocking monClk @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	// The turn, bottom, match and waveform checks restrict themselves to undivided ticks so each step is one cycle.
	wire logic pcMode = waveformMode inside {4'h1, 4'h2, 4'h3, 4'hA, 4'hB};
	wire logic pfcMode = waveformMode[3:1] == 3'h4;
	wire logic fast = clockSelect == 3'h1 && !counterWrite;
	wire logic run10 = waveformMode == 4'hA && fast;
	wire logic runAny = (pcMode || pfcMode) && fast;

	pin_enable_a: assert property (wavePinOeA_n == !wavePinDirectionA)
		else $error("pin enable A wrong");
	pin_port_a: assert property (compareModeA == 2'h0 |-> wavePinA == portDataA)
		else $error("pin A not port data");
	pin_wave_a: assert property (compareModeA[1] |-> wavePinA == waveOutA)
		else $error("pin A not waveform");
	irq_overflow_a: assert property (overflowIrq == (overflowFlag && overflowIrqEnable))
		else $error("overflow request wrong");
	top_turn_a: assert property (run10 && countingUp && counterValue == captureReg
		&& counterValue != 16'h0000 |=> !countingUp
		&& counterValue == $past(counterValue) - 16'h0001) else $error("no turn at top");
	bottom_flag_a: assert property (runAny && !countingUp && counterValue == 16'h0000
		|=> overflowFlag && countingUp && counterValue == 16'h0001)
		else $error("bottom turn or overflow wrong");
	pc_load_a: assert property (pcMode && $changed(compareRegB)
		|-> $past(countingUp) && !countingUp) else $error("load not at top");
	pfc_load_a: assert property (pfcMode && $changed(compareRegB)
		|-> overflowFlag && $rose(countingUp)) else $error("load not at bottom");
	match_flag_a: assert property (run10 && counterValue == compareRegB
		|=> compareMatchFlagB) else $error("match flag B missing");
	up_clear_a: assert property (compareModeB == 2'h2 && run10 && countingUp
		&& counterValue == compareRegB && counterValue != captureReg |=> !waveOutB)
		else $error("up match did not clear B");
	down_set_a: assert property (compareModeB == 2'h2 && run10 && !countingUp
		&& counterValue == compareRegB && counterValue != 16'h0000 |=> waveOutB)
		else $error("down match did not set B");
	reset_state_a: assert property ($rose(resetn) |-> counterValue == 16'h0000
		&& countingUp && !waveOutA && !waveOutB && !overflowFlag)
		else $error("reset state wrong");
endmodule : pwm_timer_monitor
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
bind dual_slope_pwm_timer16 pwm_timer_monitor u_pwm_timer_monitor
(
	.core_clk, .resetn, .clockSelect, .waveformMode, .compareModeA,
	.compareModeB, .counterWrite, .overflowIrqEnable, .wavePinDirectionA,
	.portDataA, .counterValue, .countingUp, .compareRegB, .captureReg,
	.overflowFlag, .compareMatchFlagB, .overflowIrq, .waveOutA, .waveOutB,
	.wavePinA, .wavePinOeA_n
);
module testbench;
	import pwm_timer_pkg::*;
	logic       core_clk, resetn, countingUp;
	logic [2:0] clockSelect;
	logic [3:0] waveformMode;
	logic [1:0] compareModeA, compareModeB;
	logic       compareWriteA, compareWriteB, captureWrite, counterWrite;
	count_t     compareWriteData, captureWriteData, counterWriteData;
	logic       overflowClear, overflowServiced, compareClearA, compareClearB;
	logic       compareServicedA, compareServicedB, captureClear;
	logic       captureServiced, overflowIrqEnable, compareIrqEnableA;
	logic       compareIrqEnableB, captureIrqEnable, portDataA, portDataB;
	logic       wavePinDirectionA, wavePinDirectionB;
	count_t     counterValue, compareRegA, compareRegB, captureReg;
	logic       overflowFlag, compareMatchFlagA, compareMatchFlagB;
	logic       captureFlag, overflowIrq, compareIrqA, compareIrqB, captureIrq;
	logic       waveOutA, waveOutB, wavePinA, wavePinB;
	logic       wavePinOeA_n, wavePinOeB_n;
	int         num_errors, checks_done, cnt;

	dual_slope_pwm_timer16 #(.PrescaleWidth(10)) u_dual_slope_pwm_timer16
	(
		.core_clk, .resetn, .clockSelect, .waveformMode, .compareModeA,
		.compareModeB, .compareWriteA, .compareWriteB, .compareWriteData,
		.captureWrite, .captureWriteData, .counterWrite, .counterWriteData,
		.overflowClear, .overflowServiced, .compareClearA, .compareServicedA,
		.compareClearB, .compareServicedB, .captureClear, .captureServiced,
		.overflowIrqEnable, .compareIrqEnableA, .compareIrqEnableB,
		.captureIrqEnable, .wavePinDirectionA, .wavePinDirectionB, .portDataA,
		.portDataB, .counterValue, .countingUp, .compareRegA, .compareRegB,
		.captureReg, .overflowFlag, .compareMatchFlagA, .compareMatchFlagB,
		.captureFlag, .overflowIrq, .compareIrqA, .compareIrqB, .captureIrq,
		.waveOutA, .waveOutB, .wavePinA, .wavePinB, .wavePinOeA_n,
		.wavePinOeB_n
	);

	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic summarize;
		$display("Mismatches %0d, checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic step;
		@(posedge core_clk);
		#1;
	endtask : step

	task automatic do_reset;
		resetn = 1'b0;
		clockSelect = 3'h0;
		repeat (2) step;
		resetn = 1'b1;
		step;
	endtask : do_reset

	// A cycle model of the counter, buffers, flags and waveform levels.
	task automatic run(input logic [3:0] md, input logic [1:0] ma, mb,
		input count_t cap, ca, cb, input int n, wrAt, input count_t na);
		count_t c, top, msk, aA, aB, bA, bB;
		logic up, fO, fA, fB, fC, wA, wB, tE, bE, lvl;
		do_reset;
		msk = md == 4'h1 ? 16'h00FF : md == 4'h2 ? 16'h01FF : 16'hFFFF;
		waveformMode = md;
		compareModeA = ma;
		compareModeB = mb;
		{captureWrite, compareWriteA} = 2'h3;
		captureWriteData = cap;
		compareWriteData = ca;
		step;
		{captureWrite, compareWriteA, compareWriteB} = 3'h1;
		compareWriteData = cb;
		step;
		compareWriteB = 1'b0;
		check({compareRegA, captureReg}, {16'h0000, cap});
		{c, aA, aB, fO, fA, fB, fC, wA, wB} = '0;
		up = 1'b1;
		bA = ca & msk;
		bB = cb & msk;
		clockSelect = 3'h1;
		for (int i = 0; i < n; i++)
		begin
			check(c, counterValue);
			check({fO, fC, fA, fB, up}, {overflowFlag, captureFlag,
				compareMatchFlagA, compareMatchFlagB, countingUp});
			check({wA, wB}, {waveOutA, waveOutB});
			check({aA, aB}, {compareRegA, compareRegB});
			check({fA, fB, fC, wB, 1'b1}, {compareIrqA, compareIrqB,
				captureIrq, wavePinB, wavePinOeB_n});
			top = md[3] ? (md[0] ? aA : cap) : msk;
			tE = up && c == top;
			bE = !up && c == 16'h0000;
			lvl = c == 16'h0000 ? 1'b0 : c == top ? 1'b1 : !up;
			if (c == aA)
				wA = ma == 2'h1 ? !wA : lvl ^ (ma == 2'h3);
			if (c == aB)
				wB = lvl ^ (mb == 2'h3);
			fA |= c == aA;
			fB |= c == aB;
			fO |= bE;
			fC |= tE && md[3] && !md[0];
			if ((md[3:1] == 3'h4) ? bE : tE)
				{aA, aB} = {bA, bB};
			compareWriteA = i == wrAt;
			compareWriteData = na;
			if (i == wrAt)
				bA = na & msk;
			c = tE ? c - 16'h0001 : bE ? 16'h0001 : up ? c + 16'h0001 : c - 16'h0001;
			up = tE ? 1'b0 : bE ? 1'b1 : up;
			step;
		end
		clockSelect = 3'h0;
		compareWriteA = 1'b0;
		repeat (2) step;
	endtask : run

	task automatic clear_flags(input logic s);
		{overflowClear, compareServicedA, compareClearB, captureServiced} = {4{s}};
		{overflowServiced, compareClearA, compareServicedB, captureClear} = {4{!s}};
		step;
		{overflowClear, compareServicedA, compareClearB, captureServiced} = '0;
		{overflowServiced, compareClearA, compareServicedB, captureClear} = '0;
		check({overflowFlag, compareMatchFlagA, compareMatchFlagB, captureFlag}, 0);
	endtask : clear_flags

	// The first interval may include prescaler start-up, so only a full one counts.
	task automatic wait_change;
		count_t c0;
		c0 = counterValue;
		cnt = 0;
		while (counterValue === c0 && cnt < 200)
		begin
			step;
			cnt++;
		end
		if (cnt == 200)
		begin
			num_errors++;
			summarize;
		end
	endtask : wait_change

	initial
	begin
		{resetn, clockSelect, waveformMode, compareModeA, compareModeB} = '0;
		{compareWriteA, compareWriteB, captureWrite, counterWrite} = '0;
		{compareWriteData, captureWriteData, counterWriteData} = '0;
		{overflowClear, overflowServiced, compareClearA, compareClearB} = '0;
		{compareServicedA, compareServicedB, captureClear, captureServiced} = '0;
		{overflowIrqEnable, compareIrqEnableA, compareIrqEnableB} = 3'h7;
		{captureIrqEnable, wavePinDirectionA, wavePinDirectionB} = 3'h6;
		{portDataA, portDataB, num_errors, checks_done} = '0;
		run(4'hA, 2'h2, 2'h2, 16'h0005, 16'h0005, 16'h0003, 40, -1, 16'h0000);
		clear_flags(1'b1);
		run(4'h8, 2'h3, 2'h2, 16'h0006, 16'h0000, 16'h0006, 40, -1, 16'h0000);
		clear_flags(1'b0);
		run(4'hB, 2'h1, 2'h3, 16'h0000, 16'h0004, 16'h0000, 40, 15, 16'h0006);
		run(4'h9, 2'h2, 2'h2, 16'h0000, 16'h0005, 16'h0007, 40, 3, 16'h0003);
		run(4'h1, 2'h2, 2'h3, 16'h0000, 16'h1234, 16'h00FF, 520, -1, 16'h0000);
		for (int k = 0; k < 2; k++)
		begin
			do_reset;
			waveformMode = 4'h1;
			clockSelect = k ? 3'h3 : 3'h2;
			wait_change;
			wait_change;
			check(cnt, k ? 64 : 8);
		end
		summarize;
	end
endmodule : testbench
`default_nettype wire
